// ===== continuous_serial_unit.sv
// Purpose: continuous synchronous serial transfer between RAM and a shift
//          register, with a 16-bit programmable CRC
// Assumes: RAM answers a read strobe with data one clock later
// Notes:   all state freezes while ce is low
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module continuous_serial_unit (
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      ce,
	input  wire logic [15:0]               reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic      [7:0]                reg_rdata,
	output logic      [csu_pkg::RAM_AW-1:0] ram_addr,
	output logic                           ram_rd,
	input  wire logic [7:0]                ram_rdata,
	output logic                           ram_wr,
	output logic      [7:0]                ram_wdata,
	input  wire logic                      data_pin_a_in,
	output logic                           data_pin_a_out,
	output logic                           data_pin_a_oe,
	input  wire logic                      data_pin_b_in,
	output logic                           data_pin_b_out,
	output logic                           data_pin_b_oe,
	input  wire logic                      bit_clock_pin_in,
	output logic                           bit_clock_pin_out,
	output logic                           bit_clock_pin_oe,
	input  wire logic [3:0]                pause_pins,
	output logic                           irq
);
	import csu_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// software registers
	logic [7:0]  addr_lo_reg;
	logic [7:0]  addr_hi_reg;
	logic [7:0]  cnt_lo_reg;
	logic [7:0]  cnt_hi_reg;
	logic [15:0] poly_reg;
	logic [7:0]  crc_ctl_reg;
	logic [7:0]  main_reg;
	logic [7:0]  setup_reg;
	logic [7:0]  baud_reg;
	logic        run_reg;
	logic        done_reg;

	// engine state
	state_t               state_reg;
	logic [7:0]           shift_reg;
	logic [15:0]          crc_reg;
	logic [2:0]           bit_cnt_reg;
	logic [CNT_W-1:0]     remain_reg;
	logic                 odd_reg;
	logic [7:0]           rate_cnt_reg;
	logic [1:0]           pre_reg;
	logic                 sck_reg;
	logic                 out_bit_reg;

	// synchronisers
	logic [1:0] sck_sync_reg;
	logic       sck_prev_reg;
	logic [1:0] a_sync_reg;
	logic [1:0] b_sync_reg;
	logic [3:0] pause_s1_reg;
	logic [3:0] pause_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// address decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = (a == off);
	endfunction

	wire wr_addr_lo = reg_wr & hit(reg_addr, OFF_ADDR_LO);
	wire wr_addr_hi = reg_wr & hit(reg_addr, OFF_ADDR_HI);
	wire wr_cnt_lo  = reg_wr & hit(reg_addr, OFF_CNT_LO);
	wire wr_cnt_hi  = reg_wr & hit(reg_addr, OFF_CNT_HI);
	wire wr_crc_lo  = reg_wr & hit(reg_addr, OFF_CRC_LO);
	wire wr_crc_hi  = reg_wr & hit(reg_addr, OFF_CRC_HI);
	wire wr_crc_ctl = reg_wr & hit(reg_addr, OFF_CRC_CTL);
	wire wr_main    = reg_wr & hit(reg_addr, OFF_MAIN);
	wire wr_setup   = reg_wr & hit(reg_addr, OFF_SETUP);
	wire wr_shift   = reg_wr & hit(reg_addr, OFF_SHIFT);
	wire wr_baud    = reg_wr & hit(reg_addr, OFF_BAUD);

	// control bits in use
	wire master     = setup_reg[SU_MASTER];
	wire msb_first  = main_reg[MC_ORDER];
	wire edge_sel   = main_reg[MC_EDGE];
	wire idle_level = ~edge_sel;                     // leading edge drives
	wire res_view   = crc_ctl_reg[CC_SEL];

	////////////////////////////////////////////////////////////////////////
	// read mux, polynomial or result on the CRC pair
	wire [15:0] crc_view = res_view ? crc_reg : poly_reg;
	wire [7:0]  main_view = {run_reg, main_reg[6:2], done_reg, main_reg[MC_IE]};
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			OFF_ADDR_LO: rd_mux = addr_lo_reg;
			OFF_ADDR_HI: rd_mux = addr_hi_reg;
			OFF_CNT_LO:  rd_mux = cnt_lo_reg;
			OFF_CNT_HI:  rd_mux = cnt_hi_reg;
			OFF_CRC_LO:  rd_mux = crc_view[7:0];
			OFF_CRC_HI:  rd_mux = crc_view[15:8];
			OFF_CRC_CTL: rd_mux = crc_ctl_reg;
			OFF_MAIN:    rd_mux = main_view;
			OFF_SETUP:   rd_mux = setup_reg;
			OFF_SHIFT:   rd_mux = shift_reg;
			OFF_BAUD:    rd_mux = baud_reg;
			default:     rd_mux = RESET_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// input synchronisers; only second stages feed logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_sync_reg <= 2'h3;   // pin idles high, so no false edge
			sck_prev_reg <= 1'b1;
			a_sync_reg   <= 2'h0;
			b_sync_reg   <= 2'h0;
			pause_s1_reg <= 4'h0;
			pause_s2_reg <= 4'h0;
		end else if (ce) begin
			sck_sync_reg <= {sck_sync_reg[0], bit_clock_pin_in};
			sck_prev_reg <= sck_sync_reg[1];
			a_sync_reg   <= {a_sync_reg[0], data_pin_a_in};
			b_sync_reg   <= {b_sync_reg[0], data_pin_b_in};
			pause_s1_reg <= pause_pins;
			pause_s2_reg <= pause_s1_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bit clock: reload counter as master, pin edges as slave
	wire shifting  = (state_reg == ST_SHIFT);
	wire pre_done  = (pre_reg == PRE_LAST);
	wire rate_exp  = (rate_cnt_reg <= 8'h01);
	wire m_toggle  = shifting & master & pre_done & rate_exp;
	wire s_change  = sck_sync_reg[1] ^ sck_prev_reg;
	wire s_lead    = shifting & ~master & s_change & (sck_prev_reg == idle_level);
	wire s_trail   = shifting & ~master & s_change & (sck_prev_reg != idle_level);
	wire lead      = (m_toggle & (sck_reg == idle_level)) | s_lead;
	wire trail     = (m_toggle & (sck_reg != idle_level)) | s_trail;
	wire in_bit    = setup_reg[SU_IN_A] ? a_sync_reg[1] : b_sync_reg[1];
	wire cur_bit   = msb_first ? shift_reg[7] : shift_reg[0];
	wire last_bit  = trail & (bit_cnt_reg == LAST_BIT);

	// down counter halves the period, reloaded from the rate register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pre_reg      <= 2'h0;
			rate_cnt_reg <= RESET_BYTE;
			sck_reg      <= 1'b1;
		end else if (ce) begin
			if (!shifting) begin
				pre_reg      <= 2'h0;
				rate_cnt_reg <= baud_reg;
				sck_reg      <= idle_level;
			end else if (master) begin
				pre_reg <= pre_done ? 2'h0 : 2'(pre_reg + 2'h1);
				if (pre_done)
					rate_cnt_reg <= rate_exp ? baud_reg : 8'(rate_cnt_reg - 8'h01);
				if (m_toggle)
					sck_reg <= ~sck_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pause decision at each byte boundary
	wire [1:0] psel      = {crc_ctl_reg[CC_PSEL_HI], crc_ctl_reg[CC_PSEL_LO]};
	wire       pin_level = pause_s2_reg[psel];
	wire       pin_pause = crc_ctl_reg[CC_PEN] &
	                       (pin_level == crc_ctl_reg[CC_POL]);
	wire       pair_ok   = ~cnt_hi_reg[CH_PAIR] | odd_reg;
	wire       pause_now = master & pair_ok &
	                       (addr_hi_reg[AH_PAUSE] | pin_pause);

	// transfer geometry
	wire [RAM_AW-1:0] start_addr = {addr_hi_reg[4:0], addr_lo_reg};
	wire [CNT_W-1:0]  cnt_field  = {cnt_hi_reg[CH_MSB:0], cnt_lo_reg};
	wire [CNT_W-1:0]  total      = (cnt_field == '0) ? FULL_COUNT : cnt_field;
	wire              start      = wr_main & reg_wdata[MC_RUN] & ~run_reg;
	wire              stop       = wr_main & ~reg_wdata[MC_RUN];
	wire              last_byte  = (remain_reg == 14'd1);
	wire              finish     = (state_reg == ST_STORE) & last_byte;

	////////////////////////////////////////////////////////////////////////
	// byte sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= ST_IDLE;
			remain_reg  <= '0;
			odd_reg     <= 1'b0;
			bit_cnt_reg <= 3'h0;
			ram_addr    <= '0;
			ram_rd      <= 1'b0;
		end else if (ce) begin
			ram_rd <= 1'b0;
			if (stop) begin
				state_reg <= ST_IDLE;
			end else begin
				case (state_reg)
					ST_IDLE: begin
						if (start) begin
							remain_reg <= total;
							odd_reg    <= 1'b0;
							ram_addr   <= start_addr;
							ram_rd     <= 1'b1;
							state_reg  <= ST_FETCH;
						end
					end
					ST_FETCH: state_reg <= ST_LOAD;
					ST_LOAD: begin
						bit_cnt_reg <= 3'h0;
						state_reg   <= ST_SHIFT;
					end
					ST_SHIFT: begin
						if (trail)
							bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
						if (last_bit)
							state_reg <= ST_STORE;
					end
					ST_STORE: begin
						remain_reg <= CNT_W'(remain_reg - 14'd1);
						odd_reg    <= ~odd_reg;
						if (last_byte) begin
							state_reg <= ST_IDLE;
						end else begin
							ram_addr <= RAM_AW'(ram_addr + 13'd1);
							if (pause_now) begin
								state_reg <= ST_PAUSE;
							end else begin
								ram_rd    <= 1'b1;
								state_reg <= ST_FETCH;
							end
						end
					end
					ST_PAUSE: begin
						// odd_reg has flipped, so pairs stay held here
						if (!(master & (addr_hi_reg[AH_PAUSE] | pin_pause))) begin
							ram_rd    <= 1'b1;
							state_reg <= ST_FETCH;
						end
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shift register, RAM write back and data output bit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_reg   <= RESET_BYTE;
			out_bit_reg <= 1'b1;
			ram_wr      <= 1'b0;
			ram_wdata   <= RESET_BYTE;
		end else if (ce) begin
			ram_wr <= 1'b0;
			if (state_reg == ST_LOAD)
				shift_reg <= ram_rdata;
			else if (trail)
				shift_reg <= msb_first ? {shift_reg[6:0], in_bit}
				                       : {in_bit, shift_reg[7:1]};
			else if (wr_shift && state_reg == ST_IDLE)
				shift_reg <= reg_wdata;
			if (lead)
				out_bit_reg <= cur_bit;
			// write lands while the pointer still holds this byte
			if (last_bit && main_reg[MC_XCHG]) begin
				ram_wr    <= 1'b1;
				ram_wdata <= msb_first ? {shift_reg[6:0], in_bit}
				                       : {in_bit, shift_reg[7:1]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// CRC engine, one step per sampled bit
	wire        crc_fb   = crc_reg[15] ^ in_bit;
	wire [15:0] crc_step = {crc_reg[14:0], 1'b0} ^ (crc_fb ? poly_reg : RESET_WORD);
	wire [15:0] crc_init = crc_ctl_reg[CC_ONES] ? CRC_ONES : RESET_WORD;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			crc_reg <= RESET_WORD;
		end else if (ce) begin
			if (!crc_ctl_reg[CC_KEEP])
				crc_reg <= crc_init;
			else if (crc_ctl_reg[CC_RUN] && trail)
				crc_reg <= crc_step;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes; polynomial writable only in polynomial view
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			addr_lo_reg <= RESET_BYTE;
			addr_hi_reg <= RESET_BYTE;
			cnt_lo_reg  <= RESET_BYTE;
			cnt_hi_reg  <= RESET_BYTE;
			poly_reg    <= RESET_WORD;
			crc_ctl_reg <= RESET_BYTE;
			main_reg    <= RESET_BYTE;
			setup_reg   <= RESET_BYTE;
			baud_reg    <= RESET_BYTE;
		end else if (ce) begin
			if (wr_addr_lo) addr_lo_reg <= reg_wdata;
			if (wr_addr_hi) addr_hi_reg <= reg_wdata;
			if (wr_cnt_lo)  cnt_lo_reg  <= reg_wdata;
			if (wr_cnt_hi)  cnt_hi_reg  <= reg_wdata;
			if (wr_crc_lo && !res_view) poly_reg[7:0]  <= reg_wdata;
			if (wr_crc_hi && !res_view) poly_reg[15:8] <= reg_wdata;
			if (wr_crc_ctl) crc_ctl_reg <= reg_wdata;
			if (wr_main)    main_reg    <= reg_wdata;
			if (wr_setup)   setup_reg   <= reg_wdata;
			if (wr_baud)    baud_reg    <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run and done flags; a hardware set beats a same-cycle clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
			irq      <= 1'b0;
		end else if (ce) begin
			if (start)
				run_reg <= 1'b1;
			else if (stop || finish)
				run_reg <= 1'b0;
			done_reg <= finish | (done_reg & ~(wr_main & ~reg_wdata[MC_DONE]));
			irq      <= done_reg & main_reg[MC_IE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers; open drain pins only pull low
	wire drive_bit = lead ? cur_bit : out_bit_reg;
	wire sck_next  = m_toggle ? ~sck_reg : (shifting ? sck_reg : idle_level);
	wire a_en      = run_reg & setup_reg[SU_A_OUT];
	wire b_en      = run_reg & setup_reg[SU_B_OUT];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_pin_a_out    <= 1'b0;
			data_pin_a_oe     <= 1'b0;
			data_pin_b_out    <= 1'b0;
			data_pin_b_oe     <= 1'b0;
			bit_clock_pin_out <= 1'b0;
			bit_clock_pin_oe  <= 1'b0;
			reg_rdata         <= RESET_BYTE;
		end else if (ce) begin
			data_pin_a_out    <= setup_reg[SU_A_CMOS] & drive_bit;
			data_pin_a_oe     <= a_en & (setup_reg[SU_A_CMOS] | ~drive_bit);
			data_pin_b_out    <= setup_reg[SU_B_CMOS] & drive_bit;
			data_pin_b_oe     <= b_en & (setup_reg[SU_B_CMOS] | ~drive_bit);
			bit_clock_pin_out <= setup_reg[SU_CK_CMOS] & sck_next;
			bit_clock_pin_oe  <= master & (setup_reg[SU_CK_CMOS] | ~sck_next);
			reg_rdata         <= reg_rd ? rd_mux : RESET_BYTE;
		end
	end
endmodule
`default_nettype wire

// ===== continuous_serial_unit_tb_top.sv
// Purpose: self-checking bench for the continuous serial unit
// Assumes: master mode, pin a out, pin b in, clock and pin a cmos
// Notes:   RAM model answers one clock after the address
`timescale 1ns/1ps
`default_nettype none
module continuous_serial_unit_tb_top;
	import csu_pkg::*;
	logic clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, ram_rd, ram_wr, irq;
	logic a_out, a_oe, b_out, b_oe, ck_out, ck_oe, peer_sdo;
	logic [15:0] reg_addr = 16'h0000, crc_exp;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, ram_rdata = 8'h00, ram_wdata, peer_rx, peer_n;
	logic [7:0]  v, n0, mem [0:8191];
	logic [12:0] ram_addr;
	logic [3:0]  pause_pins = 4'h0;
	logic        ce = 1'b1;
	int          fail_count = 0, n_checks = 0, cyc = 0, i, k;
	wire         sck = ck_oe ? ck_out : 1'b1;
	wire         a_wire = a_oe ? a_out : 1'b1;
	continuous_serial_unit dut (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ram_addr(ram_addr), .ram_rd(ram_rd), .ram_rdata(ram_rdata), .ram_wr(ram_wr),
		.ram_wdata(ram_wdata), .data_pin_a_in(a_wire), .data_pin_a_out(a_out),
		.data_pin_a_oe(a_oe), .data_pin_b_in(b_oe ? b_out : peer_sdo), .data_pin_b_out(b_out),
		.data_pin_b_oe(b_oe), .bit_clock_pin_in(sck), .bit_clock_pin_out(ck_out),
		.bit_clock_pin_oe(ck_oe), .pause_pins(pause_pins), .irq(irq));
	csu_peer peer (.act(resetn), .sck(sck), .sdi(a_wire), .tx(8'h35), .sdo(peer_sdo),
		.rx(peer_rx), .nbytes(peer_n));
	always #10 clk = ~clk;
	// ram model and run-length guard
	always @(posedge clk) begin
		ram_rdata <= mem[ram_addr];
		if (ram_wr) mem[ram_addr] <= ram_wdata;
		cyc = cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			final_report;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdv(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rdv(a, d);
		chk("reg", {8'h00, e}, {8'h00, d});
	endtask
	// poll the run flag, bounded
	task automatic wait_idle;
		int j;
		j = 0;
		do begin
			rdv(OFF_MAIN, v);
			j++;
		end while (v[MC_RUN] !== 1'b0 && j < 400);
		chk("idle", 16'h0000, {15'h0, v[MC_RUN]});
	endtask
	task automatic final_report;
		if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// software model of the crc, msb of each received byte first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic fb;
		for (int j = 7; j >= 0; j--) begin
			fb = c[15] ^ b[j];
			c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		mem[16'h1010] = 8'h3c;
		mem[16'h1011] = 8'h81;
		mem[16'h1012] = 8'h0f;
		mem[16'h1013] = 8'h77;
		mem[16'h0020] = 8'h12;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		for (i = 0; i < 12; i++) rd(OFF_ADDR_LO + 16'(i), 8'h00); // reset values, unmapped last
		wr(OFF_BAUD, 8'h04);
		rd(OFF_BAUD, 8'h04);
		wr(OFF_CRC_LO, 8'h21);
		wr(OFF_CRC_HI, 8'h10);
		rd(OFF_CRC_HI, 8'h10);
		wr(OFF_CRC_CTL, 8'h30);
		rd(OFF_CRC_LO, 8'hff);
		wr(OFF_CRC_CTL, 8'h20);
		rd(OFF_CRC_HI, 8'h00);
		wr(OFF_CRC_CTL, 8'h10);
		wr(OFF_CRC_CTL, 8'hd0);
		// three bytes, msb first, exchange, interrupt enabled
		wr(OFF_ADDR_LO, 8'h10);
		wr(OFF_ADDR_HI, 8'h10);
		wr(OFF_CNT_LO, 8'h03);
		wr(OFF_SETUP, 8'h53);
		wr(OFF_MAIN, 8'ha5);
		wait_idle;
		for (i = 0; i < 3; i++) chk("ram", 16'h0035, {8'h00, mem[16'h1010 + i]});
		chk("ram end", 16'h0077, {8'h00, mem[16'h1013]});
		chk("peer n", 16'h0003, {8'h00, peer_n});
		chk("peer rx", 16'h000f, {8'h00, peer_rx});
		chk("pins off", 16'h0000, {14'h0, a_oe, b_oe});
		rd(OFF_MAIN, 8'h27);
		chk("irq", 16'h0001, {15'h0, irq});
		crc_exp = crc_byte(crc_byte(crc_byte(16'hffff, 8'h35), 8'h35), 8'h35);
		wr(OFF_CRC_CTL, 8'hf0);
		rd(OFF_CRC_LO, crc_exp[7:0]);
		rd(OFF_CRC_HI, crc_exp[15:8]);
		wr(OFF_MAIN, 8'h00);
		rd(OFF_MAIN, 8'h00);
		chk("irq", 16'h0000, {15'h0, irq});
		// one byte, lsb first, interrupt masked
		wr(OFF_ADDR_HI, 8'h00);
		wr(OFF_ADDR_LO, 8'h20);
		wr(OFF_CNT_LO, 8'h01);
		wr(OFF_MAIN, 8'h84);
		wait_idle;
		chk("ram lsb", 16'h00ac, {8'h00, mem[16'h0020]});
		chk("peer lsb", 16'h0048, {8'h00, peer_rx});
		rd(OFF_MAIN, 8'h06);
		chk("irq", 16'h0000, {15'h0, irq});
		// pause by flag, by selected pin, and by flag in byte pairs
		for (k = 0; k < 3; k++) begin
			wr(OFF_MAIN, 8'h00);
			wr(OFF_ADDR_LO, 8'h30);
			wr(OFF_CNT_LO, 8'h03);
			wr(OFF_CNT_HI, (k == 2) ? 8'h80 : 8'h00);
			if (k == 1) wr(OFF_CRC_CTL, 8'h0e);
			else wr(OFF_ADDR_HI, 8'h80);
			pause_pins <= (k == 1) ? 4'h4 : 4'h1;
			n0 = peer_n;
			wr(OFF_MAIN, 8'h84);
			for (i = 0; i < 900 && peer_n != n0 + ((k == 2) ? 8'h02 : 8'h01); i++) @(posedge clk);
			repeat (400) @(posedge clk);
			chk("paused n", {8'h00, n0 + ((k == 2) ? 8'h02 : 8'h01)}, {8'h00, peer_n});
			rd(OFF_MAIN, 8'h84);
			pause_pins <= 4'h1;
			wr(OFF_ADDR_HI, 8'h00);
			wait_idle;
			chk("resumed n", {8'h00, n0 + 8'h03}, {8'h00, peer_n});
		end
		// result view refuses polynomial writes
		wr(OFF_CRC_CTL, 8'h20);
		wr(OFF_CRC_LO, 8'h55);
		wr(OFF_CRC_CTL, 8'h00);
		rd(OFF_CRC_LO, 8'h21);
		// shift register takes software writes while idle
		wr(OFF_SHIFT, 8'h5a);
		rd(OFF_SHIFT, 8'h5a);
		// clock enable low freezes a register write
		@(posedge clk);
		ce <= 1'b0;
		wr(OFF_ADDR_LO, 8'h55);
		ce <= 1'b1;
		rd(OFF_ADDR_LO, 8'h30);
		final_report;
	end
endmodule
`default_nettype wire

// ===== csu_chk.sv
// Purpose: port-level checker for the continuous serial unit
// Assumes: ce low only while idle; setup and control writes mirrored here
// Notes:   shadows only the fields the properties need
`timescale 1ns/1ps
`default_nettype none
module csu_chk (
	input wire logic                       clk,
	input wire logic                       resetn,
	input wire logic [15:0]                reg_addr,
	input wire logic [7:0]                 reg_wdata,
	input wire logic                       reg_wr,
	input wire logic [csu_pkg::RAM_AW-1:0] ram_addr,
	input wire logic                       ram_rd,
	input wire logic                       ram_wr,
	input wire logic                       data_pin_a_oe,
	input wire logic                       bit_clock_pin_out,
	input wire logic                       bit_clock_pin_oe,
	input wire logic                       irq
);
	import csu_pkg::*;
	logic [7:0] su_q, mc_q, baud_q;
	logic       ck_prev;
	logic [9:0] hcnt;
	wire        ck_edge = bit_clock_pin_out != ck_prev;
	wire  [9:0] half = (baud_q <= 8'h01) ? 10'd2 : {1'b0, baud_q, 1'b0};
	// a control write may move the idle level or abort a byte
	wire        main_wr = reg_wr && reg_addr == OFF_MAIN;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////////////
	// mirror of written fields; hcnt counts cycles since last clock change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			su_q    <= 8'h00;
			mc_q    <= 8'h00;
			baud_q  <= 8'h00;
			ck_prev <= 1'b0;
			hcnt    <= 10'h000;
		end else begin
			if (reg_wr && reg_addr == OFF_SETUP) su_q <= reg_wdata;
			if (reg_wr && reg_addr == OFF_MAIN) mc_q <= reg_wdata;
			if (reg_wr && reg_addr == OFF_BAUD) baud_q <= reg_wdata;
			ck_prev <= bit_clock_pin_out;
			hcnt    <= ck_edge ? 10'h001 : hcnt + 10'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// a pending request only drops after a software write
	irq_hold_a: assert property (irq && !reg_wr && !$past(reg_wr) |=> irq)
		else $error("irq dropped without a write");
	irq_enable_a: assert property ($rose(irq) |-> $past(mc_q[MC_IE]))
		else $error("irq rose while disabled");
	ram_rd_pulse_a: assert property (ram_rd |=> !ram_rd)
		else $error("ram read strobe longer than one cycle");
	rd_wr_excl_a: assert property (!(ram_rd && ram_wr))
		else $error("ram read and write together");
	ram_step_a: assert property (ram_wr ##1 ram_rd |-> ram_addr == $past(ram_addr) + 13'h1)
		else $error("ram pointer did not step by one");
	// trailing edge comes exactly one half period after the leading one
	half_period_a: assert property (bit_clock_pin_oe && $past(bit_clock_pin_oe) && ck_edge
		&& bit_clock_pin_out == ~mc_q[MC_EDGE] && !$past(main_wr, 2) |-> hcnt == half)
		else $error("bit clock half period wrong");
	clk_master_a: assert property (bit_clock_pin_oe |-> $past(su_q[SU_MASTER]))
		else $error("clock pin driven as slave");
	a_out_enable_a: assert property (data_pin_a_oe |-> $past(su_q[SU_A_OUT]))
		else $error("data pin a driven while not an output");
	cover property (irq);
	cover property (ram_wr ##1 ram_rd);
	cover property (bit_clock_pin_oe && ck_edge);
endmodule
bind continuous_serial_unit csu_chk u_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .ram_addr(ram_addr), .ram_rd(ram_rd),
	.ram_wr(ram_wr), .data_pin_a_oe(data_pin_a_oe), .bit_clock_pin_out(bit_clock_pin_out),
	.bit_clock_pin_oe(bit_clock_pin_oe), .irq(irq));
`default_nettype wire

// ===== csu_peer.sv
// Purpose: external serial peer, slave to the unit's bit clock
// Assumes: clock idles high, leading edge falls
// Notes:   data line inverts between frames so stale bits never match
`timescale 1ns/1ps
`default_nettype none
module csu_peer (
	input wire logic       act,
	input wire logic       sck,
	input wire logic       sdi,
	input wire logic [7:0] tx,
	output logic           sdo,
	output logic [7:0]     rx,
	output logic [7:0]     nbytes
);
	int         i = 0;
	logic [7:0] sh = 8'h00;
	initial begin
		sdo = 1'b1;
		rx = 8'h00;
		nbytes = 8'h00;
	end
	// drive msb first on the leading edge
	always @(negedge sck) if (act) sdo = tx[7 - i];
	// sample on the trailing edge; invert data line after eight bits
	always @(posedge sck) begin
		if (act) begin
			sh = {sh[6:0], sdi};
			i = i + 1;
			if (i == 8) begin
				i = 0;
				rx = sh;
				nbytes = nbytes + 8'h01;
				sdo = ~sdo;
			end
		end
	end
endmodule
`default_nettype wire

// ===== csu_pkg.sv
// Purpose: shared constants and types of the continuous serial unit
// Assumes: byte-wide register port with 16-bit addresses
// Notes:   one instruction cycle is three system clocks
`default_nettype none
package csu_pkg;

	// register offsets
	localparam logic [15:0] OFF_ADDR_LO  = 16'hfed6;
	localparam logic [15:0] OFF_CNT_HI   = 16'hfed7;
	localparam logic [15:0] OFF_CRC_LO   = 16'hfed8;
	localparam logic [15:0] OFF_CRC_HI   = 16'hfed9;
	localparam logic [15:0] OFF_CRC_CTL  = 16'hfeda;
	localparam logic [15:0] OFF_MAIN     = 16'hfedb;
	localparam logic [15:0] OFF_SETUP    = 16'hfedc;
	localparam logic [15:0] OFF_SHIFT    = 16'hfedd;
	localparam logic [15:0] OFF_BAUD     = 16'hfede;
	localparam logic [15:0] OFF_ADDR_HI  = 16'hfedf;
	localparam logic [15:0] OFF_CNT_LO   = 16'hfee0;

	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam logic [15:0] RESET_WORD   = 16'h0000;
	localparam logic [15:0] CRC_ONES     = 16'hffff;

	// checksum_control fields
	localparam int CC_RUN      = 7;
	localparam int CC_KEEP     = 6;
	localparam int CC_SEL      = 5;
	localparam int CC_ONES     = 4;
	localparam int CC_PEN      = 3;
	localparam int CC_POL      = 2;
	localparam int CC_PSEL_HI  = 1;
	localparam int CC_PSEL_LO  = 0;

	// serial_main_control fields
	localparam int MC_RUN      = 7;
	localparam int MC_ORDER    = 5;
	localparam int MC_EDGE     = 3;
	localparam int MC_XCHG     = 2;
	localparam int MC_DONE     = 1;
	localparam int MC_IE       = 0;

	// serial_port_setup fields
	localparam int SU_CK_CMOS  = 6;
	localparam int SU_IN_A     = 5;
	localparam int SU_MASTER   = 4;
	localparam int SU_B_CMOS   = 3;
	localparam int SU_B_OUT    = 2;
	localparam int SU_A_CMOS   = 1;
	localparam int SU_A_OUT    = 0;

	// high address and high count fields
	localparam int AH_PAUSE    = 7;
	localparam int AH_MSB      = 5;
	localparam int CH_PAIR     = 7;
	localparam int CH_MSB      = 5;

	// sizes
	localparam int RAM_AW      = 13;
	localparam int CNT_W       = 14;
	localparam logic [CNT_W-1:0] FULL_COUNT = 14'd8192;
	localparam logic [2:0]  LAST_BIT    = 3'h7;

	// timing: period is 4n/3 instruction cycles, three clocks each
	localparam int TCYC_CLKS     = 3;
	localparam int PERIOD_NUM    = 4;
	localparam int PERIOD_DEN    = 3;
	localparam int HALF_CLKS     = TCYC_CLKS * PERIOD_NUM / PERIOD_DEN / 2;
	localparam logic [1:0] PRE_LAST = 2'(HALF_CLKS - 1);

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_FETCH = 6'b000010,
		ST_LOAD  = 6'b000100,
		ST_SHIFT = 6'b001000,
		ST_STORE = 6'b010000,
		ST_PAUSE = 6'b100000
	} state_t;

endpackage
`default_nettype wire
